/* File: rtl/stf_pkg.sv */
// Shared constants, carriers and helpers for the transmit status flag block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses of 8 bits.
package stf_pkg;

	// Register bus widths.
	localparam int          STF_AW          = 8;
	localparam int          STF_DW          = 32;

	// Register byte offsets.
	localparam logic [7:0]  STF_OFF_COND    = 8'h00;
	localparam logic [7:0]  STF_OFF_CFG     = 8'h04;
	localparam logic [7:0]  STF_OFF_IST     = 8'h08;
	localparam logic [7:0]  STF_OFF_ICLR    = 8'h0C;
	localparam logic [7:0]  STF_OFF_IEN     = 8'h10;

	// Field positions in the port condition word.
	localparam int          STF_B_AGG       = 0;
	localparam int          STF_B_OCC_LO    = 1;
	localparam int          STF_B_OCC_HI    = 3;
	localparam int          STF_B_STARVED   = 4;
	localparam int          STF_B_TXDONE    = 5;
	localparam int          STF_COND_W      = 16;

	// Field positions in the configuration register.
	localparam int          STF_B_MASTER    = 0;
	localparam int          STF_B_TOS       = 1;
	localparam int          STF_B_PURGE     = 2;

	// Bit positions in the interrupt status, clear and enable registers.
	localparam int          STF_I_TXDONE    = 0;
	localparam int          STF_I_STARVED   = 1;
	localparam int          STF_I_OTHER     = 2;
	localparam int          STF_IRQ_W       = 3;

	// Queue depth and occupancy width.
	localparam int          STF_DEPTH       = 4;
	localparam int          STF_OCC_W       = 3;

	// Reset values.
	localparam logic [2:0]  STF_CFG_RST     = 3'h0;
	localparam logic [2:0]  STF_IEN_RST     = 3'h0;

	// Bus response codes.
	localparam logic [1:0]  STF_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  STF_RESP_SLVERR = 2'h2;

	// Configuration that software writes and the datapath obeys.
	typedef struct packed {
		logic purge;   // Send queue purge.
		logic tos;     // Transfer on send selection.
		logic master;  // Master mode when high.
	} stf_cfg_type;

	// One-cycle event pulses from the serial datapath.
	typedef struct packed {
		logic push;     // Byte written into the send queue.
		logic start;    // A serial transmission begins.
		logic load;     // Byte moved from queue into the shift register.
		logic shifted;  // Byte fully shifted out.
		logic tx_done;  // Configured number of bytes transmitted.
		logic other;    // Any other interrupt source of the port.
	} stf_evt_type;

	// Word index of a byte address, used by every decoder.
	function automatic logic [5:0] stf_index(input logic [7:0] addr);
		return addr[7:2];
	endfunction

endpackage

/* File: rtl/stf_occ.sv */
// Send queue occupancy counter, saturating at the queue depth.
// Assumes one-cycle push, pop and a level purge, all in the aclk domain.
`timescale 1ns/1ps
module stf_occ import stf_pkg::*; #(
	parameter int DEPTH = STF_DEPTH,
	parameter int W     = STF_OCC_W
) (
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Queue events.
	input  wire logic         push,
	input  wire logic         pop,
	input  wire logic         purge,
	// Count of valid bytes.
	output logic     [W-1:0]  count
);

	// Full and empty decodes of the current count.
	wire        at_full  = (count == W'(DEPTH));
	wire        at_empty = (count == '0);
	logic [W-1:0] next_count;

	// Next count: purge empties, a push onto a full queue overwrites the oldest.
	always_comb begin
		next_count = count;
		if (purge) begin
			next_count = '0;
		end else if (push && !pop) begin
			next_count = at_full ? count : count + W'(1);
		end else if (pop && !push) begin
			next_count = at_empty ? count : count - W'(1);
		end else if (push && pop && at_empty) begin
			next_count = W'(1);
		end
	end

	// Count register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

endmodule

/* File: rtl/stf_axil.sv */
// AXI4-Lite slave front end: catches address and data, issues strobes.
// Assumes the owner answers a read in the cycle of rd_fire, combinationally.
`timescale 1ns/1ps
module stf_axil import stf_pkg::*; (
	// Clock and reset.
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// Write address and data channels.
	input  wire logic [STF_AW-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [STF_DW-1:0]  s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	// Write response channel.
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// Read channels.
	input  wire logic [STF_AW-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [STF_DW-1:0]       s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Register strobes toward the owner.
	output logic                    wr_fire,
	output logic [STF_AW-1:0]       wr_addr,
	output logic [STF_DW-1:0]       wr_data,
	output logic [3:0]              wr_strb,
	input  wire logic               wr_err,
	output logic                    rd_fire,
	output logic [STF_AW-1:0]       rd_addr,
	input  wire logic [STF_DW-1:0]  rd_data,
	input  wire logic               rd_err
);

	logic aw_full;  // Write address held.
	logic w_full;   // Write data held.

	// Handshake decodes.
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire b_done  = s_axi_bvalid && s_axi_bready;
	wire r_done  = s_axi_rvalid && s_axi_rready;
	assign wr_fire = aw_full && w_full && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_addr = s_axi_araddr;

	// Write path: address and data in either order, then one response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= STF_RESP_OKAY;
			wr_addr       <= '0;
			wr_data       <= '0;
			wr_strb       <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_full       <= 1'b1;
				wr_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_full       <= 1'b1;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? STF_RESP_SLVERR : STF_RESP_OKAY;
			end
			if (b_done) begin
				s_axi_bvalid  <= 1'b0;
				aw_full       <= 1'b0;
				w_full        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read path: take the address, answer the next cycle, hold until taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= STF_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_err ? '0 : rd_data;
			s_axi_rresp   <= rd_err ? STF_RESP_SLVERR : STF_RESP_OKAY;
		end else if (r_done) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

/* File: rtl/stf_top.sv */
// Transmit status flags of a serial port, with summary interrupt.
// Assumes the serial datapath sends one-cycle event pulses on aclk and
// obeys the configuration outputs; software uses AXI4-Lite.
// Receive-side bits are not held here and read as zero.
`timescale 1ns/1ps
module stf_top import stf_pkg::*; (
	// Clock and reset.
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// AXI4-Lite write address channel.
	input  wire logic [STF_AW-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	// AXI4-Lite write data channel.
	input  wire logic [STF_DW-1:0]  s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// AXI4-Lite read address channel.
	input  wire logic [STF_AW-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [STF_DW-1:0]       s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Event pulses from the serial datapath.
	input  wire stf_evt_type        evt,
	// Configuration toward the serial datapath.
	output stf_cfg_type             cfg,
	// Occupancy toward the serial datapath.
	output logic [STF_OCC_W-1:0]    send_queue_occupancy,
	// Interrupt request, level.
	output logic                    irq
);

	// Register strobes from the bus front end.
	logic                wr_fire;
	logic [STF_AW-1:0]   wr_addr;
	logic [STF_DW-1:0]   wr_data;
	logic [3:0]          wr_strb;
	logic                rd_fire;
	logic [STF_AW-1:0]   rd_addr;
	logic [STF_DW-1:0]   rd_data;
	logic                wr_unmapped;  // Write hits no register.
	logic                rd_unmapped;  // Read hits no register.

	// Sticky flags of the port condition word.
	// Each stays set until a status read clears it.
	logic                tx_done_flag;
	logic                send_queue_starved_flag;
	logic                agg_flag;

	// Interrupt status and enable registers.
	// Bit zero is transmit done, then starved, then other.
	logic [STF_IRQ_W-1:0] ist;
	logic [STF_IRQ_W-1:0] ien;

	// Next values.
	logic                next_tx_done_flag;
	logic                next_starved;
	logic                next_agg;
	logic [STF_IRQ_W-1:0] next_ist;
	stf_cfg_type         next_cfg;

	// Bus front end; it owns all handshakes and the response registers.
	// A read is answered the cycle after its address is taken.
	// A write lands once both address and data are held.
	stf_axil u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_fire       (wr_fire),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_err        (wr_unmapped),
		.rd_fire       (rd_fire),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_err        (rd_unmapped)
	);

	// Write decode; the status word and status register are read-only.
	// Decoding uses the word index, so the two low address bits
	// are ignored and any byte of a word reaches that register.
	wire [5:0] wr_idx      = stf_index(wr_addr);
	wire       wr_cfg      = (wr_idx == stf_index(STF_OFF_CFG));
	wire       wr_iclr     = (wr_idx == stf_index(STF_OFF_ICLR));
	wire       wr_ien      = (wr_idx == stf_index(STF_OFF_IEN));
	wire       wr_ro       = (wr_idx == stf_index(STF_OFF_COND)) ||
	                         (wr_idx == stf_index(STF_OFF_IST));
	assign wr_unmapped = !(wr_cfg || wr_iclr || wr_ien || wr_ro);

	// Low-lane write strobes; only the low byte holds any field.
	// A write without lane zero still gets an okay response.
	wire       wr_lane0    = wr_fire && wr_strb[0];
	wire       cfg_write   = wr_lane0 && wr_cfg;
	wire       ien_write   = wr_lane0 && wr_ien;
	wire       iclr_write  = wr_lane0 && wr_iclr;

	// Read decode.
	// The clear register is decoded only so that reading it
	// returns zero with an okay response, not a slave error.
	wire [5:0] rd_idx      = stf_index(rd_addr);
	wire       rd_cond     = (rd_idx == stf_index(STF_OFF_COND));
	wire       rd_cfg      = (rd_idx == stf_index(STF_OFF_CFG));
	wire       rd_ist      = (rd_idx == stf_index(STF_OFF_IST));
	wire       rd_iclr     = (rd_idx == stf_index(STF_OFF_ICLR));
	wire       rd_ien      = (rd_idx == stf_index(STF_OFF_IEN));
	assign rd_unmapped = !(rd_cond || rd_cfg || rd_ist || rd_iclr || rd_ien);

	// A taken read of the status word clears its read-clear flags.
	// The clear lands at the edge that captures the read data,
	// so software always sees the value that it clears.
	wire       cond_read   = rd_fire && rd_cond;

	// Occupancy pop source depends on the mode.
	// In master mode a byte leaves the count once it is loaded.
	// In slave mode it stays counted until shifted out, since
	// it may wait in the shift register for the far clock.
	wire       occ_pop     = cfg.master ? evt.load : evt.shifted;

	// Occupancy counter, saturating at the queue depth.
	// A push onto a full queue overwrites the oldest byte,
	// so codes above four never appear.
	stf_occ #(
		.DEPTH (STF_DEPTH),
		.W     (STF_OCC_W)
	) u_occ (
		.aclk    (aclk),
		.aresetn (aresetn),
		.push    (evt.push),
		.pop     (occ_pop),
		.purge   (cfg.purge),
		.count   (send_queue_occupancy)
	);

	// Event decodes feeding the flags.
	// Starvation is judged on the count before this edge, so
	// a push in the same cycle as a start does not hide it.
	// Purge masks the starvation interrupt and its aggregate bit; the starved flag still sets.
	wire       tx_done_set = evt.tx_done && cfg.tos;
	wire       queue_empty = (send_queue_occupancy == '0);
	wire       starve_set  = evt.start && queue_empty;
	wire       starve_irq  = starve_set && !cfg.purge;

	// Interrupt sources of the whole port, as one vector.
	// The aggregate bit and the status register both follow
	// it, so they never disagree about what happened.
	wire [STF_IRQ_W-1:0] src;
	assign src[STF_I_TXDONE]  = tx_done_set;
	assign src[STF_I_STARVED] = starve_irq;
	assign src[STF_I_OTHER]   = evt.other;

	// Clear mask from the write-only clear register.
	// Bits written as zero leave their status alone.
	wire [STF_IRQ_W-1:0] iclr_mask = iclr_write ? wr_data[STF_IRQ_W-1:0] : '0;

	// The port condition word as software sees it.
	// Bits above five belong to the receive side, which this
	// block does not hold, so they read as zero.
	wire [STF_COND_W-1:0] cond_word;
	assign cond_word[STF_COND_W-1:STF_B_TXDONE+1]    = '0;
	assign cond_word[STF_B_TXDONE]                   = tx_done_flag;
	assign cond_word[STF_B_STARVED]                  = send_queue_starved_flag;
	assign cond_word[STF_B_OCC_HI:STF_B_OCC_LO]      = send_queue_occupancy;
	assign cond_word[STF_B_AGG]                      = agg_flag;

	// Read data selection; unmapped and write-only words read as zero.
	// The front end registers it into the read data at the
	// edge that takes the address.
	always_comb begin
		rd_data = '0;
		if (rd_cond) begin
			rd_data[STF_COND_W-1:0] = cond_word;
		end else if (rd_cfg) begin
			rd_data[STF_B_PURGE:STF_B_MASTER] = cfg;
		end else if (rd_ist) begin
			rd_data[STF_IRQ_W-1:0] = ist;
		end else if (rd_ien) begin
			rd_data[STF_IRQ_W-1:0] = ien;
		end
	end

	// Next values of the read-clear flags; a set in the read cycle wins.
	// Clears come first and sets after them, so an event in
	// the cycle of a read survives for the next read.
	// The other order would lose that event silently.
	always_comb begin
		next_tx_done_flag = tx_done_flag;
		next_starved      = send_queue_starved_flag;
		next_agg          = agg_flag;
		if (cond_read) begin
			next_tx_done_flag = 1'b0;
			next_starved      = 1'b0;
			next_agg          = 1'b0;
		end
		if (tx_done_set) begin
			next_tx_done_flag = 1'b1;
		end
		if (starve_set) begin
			next_starved = 1'b1;
		end
		if (|src) begin
			next_agg = 1'b1;
		end
	end

	// Next interrupt status; a new event beats a clear in the same cycle.
	// A bit stays set until software writes a one to clear it.
	assign next_ist = (ist & ~iclr_mask) | src;

	// Next configuration from a low-lane write.
	// Changing mode with bytes queued is left to software; the
	// counter just follows the pop source of the current mode.
	assign next_cfg = cfg_write ? stf_cfg_type'(wr_data[STF_B_PURGE:STF_B_MASTER]) : cfg;

	// Condition word flags.
	// All three return to zero on reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_done_flag            <= 1'b0;
			send_queue_starved_flag <= 1'b0;
			agg_flag                <= 1'b0;
		end else begin
			tx_done_flag            <= next_tx_done_flag;
			send_queue_starved_flag <= next_starved;
			agg_flag                <= next_agg;
		end
	end

	// Configuration register; drives the datapath directly.
	// Purge holds the count at zero while this bit is set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= stf_cfg_type'(STF_CFG_RST);
		end else begin
			cfg <= next_cfg;
		end
	end

	// Interrupt status and enable registers.
	// Status collects events even while disabled, so a later
	// enable raises the interrupt at once.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist <= '0;
			ien <= STF_IEN_RST;
		end else begin
			ist <= next_ist;
			if (ien_write) begin
				ien <= wr_data[STF_IRQ_W-1:0];
			end
		end
	end

	// Interrupt output, registered; high while an enabled status bit is set.
	// It uses the next status and enable values, so the line
	// moves at the same edge as the status register and still
	// leaves the block straight from a flop.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_ist & (ien_write ? wr_data[STF_IRQ_W-1:0] : ien));
		end
	end

endmodule

/* File: tb/stf_far.sv */
// Far-side model of the serial datapath, feeding event pulses to the block.
// Assumes the bench raises each request for one cycle after a rising edge.
`timescale 1ns/1ps
module stf_far import stf_pkg::*; (
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Events that the bench asks for.
	input  wire stf_evt_type  req,
	// Event pulses toward the block.
	output stf_evt_type       evt
);
	// Each request leaves as a one-cycle pulse, so no event is ever held over.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt <= '0;
		end else begin
			evt <= req;
		end
	end
endmodule

/* File: tb/stf_top_asserts.sv */
// Concurrent checks on the transmit status flag block, bound to its top.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module stf_top_asserts import stf_pkg::*; (
	// Clock and reset.
	input wire logic                  aclk,
	input wire logic                  aresetn,
	// Bus response and serial side.
	input wire logic                  s_axi_bvalid,
	input wire stf_evt_type           evt,
	input wire stf_cfg_type           cfg,
	input wire logic [STF_OCC_W-1:0]  send_queue_occupancy,
	// Interrupt request.
	input wire logic                  irq
);
	wire logic [2:0]  occ;    // Short name for the count.
	wire logic        hold;   // Neither purge nor push in this cycle.
	wire logic        cause;  // An event that may raise the interrupt.
	assign occ   = send_queue_occupancy;
	assign hold  = !cfg.purge && !evt.push;
	assign cause = evt.other || (evt.tx_done && cfg.tos) || (evt.start && occ == 3'h0 && !cfg.purge);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_occ_range: assert property (occ <= 3'h4)
		else $error("Occupancy above the queue depth.");
	a_occ_push: assert property (!cfg.purge && evt.push
		&& !(cfg.master ? evt.load : evt.shifted) && occ < 3'h4 |=> occ == $past(occ) + 3'h1)
		else $error("Push did not raise the occupancy by one.");
	a_occ_sat: assert property (!cfg.purge && evt.push && occ == 3'h4 |=> occ == 3'h4)
		else $error("Occupancy left saturation on a push.");
	a_master_pop: assert property (hold && cfg.master && evt.load && occ != 3'h0
		|=> occ == $past(occ) - 3'h1)
		else $error("Master load did not lower the occupancy.");
	a_master_hold: assert property (hold && cfg.master && !evt.load |=> $stable(occ))
		else $error("Master occupancy moved without a load.");
	a_slave_pop: assert property (hold && !cfg.master && evt.shifted && occ != 3'h0
		|=> occ == $past(occ) - 3'h1)
		else $error("Slave shift-out did not lower the occupancy.");
	a_slave_hold: assert property (hold && !cfg.master && !evt.shifted |=> $stable(occ))
		else $error("Slave occupancy moved before shift-out.");
	a_irq_cause: assert property ($rose(irq) |-> $past(cause) || s_axi_bvalid
		|| $past(s_axi_bvalid))
		else $error("Interrupt rose without an enabled source.");
	// Main scenarios.
	c_sat: cover property (evt.push && occ == 3'h4);
	c_irq: cover property ($rose(irq));
	c_purged_start: cover property (evt.start && occ == 3'h0 && cfg.purge);
endmodule
bind stf_top stf_top_asserts i_stf_top_asserts (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .evt(evt), .cfg(cfg),
	.send_queue_occupancy(send_queue_occupancy), .irq(irq)
);

/* File: tb/testbench.sv */
// Self-checking bench for the transmit status flag block with a reference model.
// Assumes the package, the design, the far-side model and the checker compile first.
`timescale 1ns/1ps
module testbench import stf_pkg::*;;
	// Stimulus, driven after rising edges.
	logic                  aclk    = 1'h0;
	logic                  aresetn = 1'h0;
	logic [STF_AW-1:0]     awaddr  = 8'h00;
	logic [STF_AW-1:0]     araddr  = 8'h00;
	logic [STF_DW-1:0]     wdata   = 32'h0;
	logic [3:0]            wstrb   = 4'h0;
	logic                  awvalid = 1'h0;
	logic                  wvalid  = 1'h0;
	logic                  bready  = 1'h0;
	logic                  arvalid = 1'h0;
	logic                  rready  = 1'h0;
	stf_evt_type           req     = '0;
	// Design outputs.
	logic                  awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]            bresp, rresp, r;
	logic [STF_DW-1:0]     rdata, d, e32;
	stf_evt_type           evt;
	stf_cfg_type           cfg;
	logic [STF_OCC_W-1:0]  occ;
	// Counters and reference model state.
	int                    err_total = 0;
	int                    tests_run = 0;
	int                    m_occ = 0, m_done = 0, m_st = 0, m_agg = 0;
	logic [2:0]            m_ist = 3'h0, m_ien = 3'h0, m_cfg = 3'h0;
	logic [8:0]            p;
	// Directed walk: configuration {purge, tos, master} then the event pulses.
	logic [8:0]            plan [19] = '{{3'h3, 6'h20}, {3'h3, 6'h20}, {3'h3, 6'h20},
		{3'h3, 6'h20}, {3'h3, 6'h20}, {3'h3, 6'h08}, {3'h3, 6'h04}, {3'h2, 6'h08},
		{3'h2, 6'h04}, {3'h2, 6'h24}, {3'h2, 6'h04}, {3'h2, 6'h04}, {3'h2, 6'h10},
		{3'h2, 6'h02}, {3'h0, 6'h22}, {3'h4, 6'h10}, {3'h4, 6'h01}, {3'h1, 6'h28},
		{3'h1, 6'h20}};
	always #2.5 aclk = ~aclk;
	stf_top i_stf_top (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.evt(evt), .cfg(cfg), .send_queue_occupancy(occ), .irq(irq)
	);
	stf_far i_stf_far (.aclk(aclk), .aresetn(aresetn), .req(req), .evt(evt));
	// Counts one comparison and reports a difference.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One write; each channel is released at the edge that takes it.
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] o);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		wstrb   <= s;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		o = bresp;
		bready <= 1'h0;
	endtask
	// One read, answer taken at the handshake edge.
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] o);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		v = rdata;
		o = rresp;
		rready <= 1'h0;
	endtask
	// Read and compare data and response.
	task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a, d, r);
		check(d, e);
		check({30'h0, r}, {30'h0, er});
	endtask
	// Register write that the model follows; purge empties the count at once.
	task wreg(input logic [7:0] a, input logic [2:0] v);
		wr(a, {29'h0, v}, 4'hF, r);
		check({30'h0, r}, {30'h0, STF_RESP_OKAY});
		if (a == STF_OFF_CFG) m_cfg = v;
		if (a == STF_OFF_IEN) m_ien = v;
		if (a == STF_OFF_ICLR) m_ist = m_ist & ~v;
		if (m_cfg[2]) m_occ = 0;
	endtask
	// Status word read; the model then drops its read-clear flags.
	task stat;
		e32 = {26'h0, m_done[0], m_st[0], m_occ[2:0], m_agg[0]};
		rdc(STF_OFF_COND, e32, STF_RESP_OKAY);
		m_done = 0;
		m_st   = 0;
		m_agg  = 0;
	endtask
	// One event pulse through the far side, mirrored in the model.
	task step(input stf_evt_type e);
		logic pop;
		pop = m_cfg[0] ? e.load : e.shifted;
		@(posedge aclk);
		req <= e;
		@(posedge aclk);
		req <= '0;
		@(posedge aclk);
		if (e.start && m_occ == 0) begin
			m_st     = 1;
			m_ist[1] = m_ist[1] | !m_cfg[2];
			m_agg    = m_agg | !m_cfg[2];
		end
		if (e.tx_done && m_cfg[1]) begin
			m_done   = 1;
			m_ist[0] = 1'h1;
			m_agg    = 1;
		end
		if (e.other) begin
			m_ist[2] = 1'h1;
			m_agg    = 1;
		end
		if (m_cfg[2]) m_occ = 0;
		else if (e.push && !pop && m_occ < STF_DEPTH) m_occ++;
		else if (!e.push && pop && m_occ > 0) m_occ--;
		else if (e.push && pop && m_occ == 0) m_occ = 1;
		@(negedge aclk);
		check({29'h0, occ}, {29'h0, m_occ[2:0]});
		check({31'h0, irq}, {31'h0, |(m_ist & m_ien)});
		check({29'h0, cfg}, {29'h0, m_cfg});
	endtask
	// Sets the configuration when it changes, then sends the events.
	task play(input logic [8:0] q);
		if (q[8:6] !== m_cfg) wreg(STF_OFF_CFG, q[8:6]);
		step(q[5:0]);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task results;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		void'($urandom(67865));
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		// Reset values, unmapped place, masked lane and a read-only write.
		stat;
		rdc(STF_OFF_CFG, 32'h0, STF_RESP_OKAY);
		rdc(STF_OFF_IEN, 32'h0, STF_RESP_OKAY);
		rdc(8'h20, 32'h0, STF_RESP_SLVERR);
		wr(8'h20, 32'h7, 4'hF, r);
		check({30'h0, r}, {30'h0, STF_RESP_SLVERR});
		wr(STF_OFF_CFG, 32'h7, 4'hE, r);
		wr(STF_OFF_IST, 32'h7, 4'hF, r);
		rdc(STF_OFF_CFG, 32'h0, STF_RESP_OKAY);
		rdc(STF_OFF_ICLR, 32'h0, STF_RESP_OKAY);
		wreg(STF_OFF_IEN, 3'h7);
		// Counting modes, saturation, flag sources and the purge mask.
		foreach (plan[i]) begin
			play(plan[i]);
			stat;
		end
		rdc(STF_OFF_IST, {29'h0, m_ist}, STF_RESP_OKAY);
		wreg(STF_OFF_ICLR, 3'h7);
		// Random mix; purge is kept rare so the count gets to move.
		repeat (300) begin
			p[8:6] = 3'($urandom_range(7));
			if ($urandom_range(3) != 0) p[8] = 1'h0;
			p[5:0] = 6'($urandom_range(63));
			play(p);
			case ($urandom_range(3))
				0: wreg(STF_OFF_IEN, 3'($urandom_range(7)));
				1: wreg(STF_OFF_ICLR, 3'($urandom_range(7)));
				2: stat;
				default: rdc(STF_OFF_IST, {29'h0, m_ist}, STF_RESP_OKAY);
			endcase
		end
		results;
	end
	// Watchdog against a hung handshake.
	initial begin
		#100000;
		err_total++;
		results;
	end
endmodule
